// *** hw/dma_chain_pkg.sv ***
/*
 * Shared constants and types for the four-channel chained DMA sequencer:
 * register offsets, control and status bit positions, reset values, the
 * engine states, the stall timing and the system bus request carrier.
 * Assumes a single 25 MHz clock and a 32-bit register port.
 */
package dma_chain_pkg;

  // ********************************************************************
  // Sizes and register offsets.
  // ********************************************************************
  localparam int CH_NUM = 4;
  localparam int CTL_W = 9;
  localparam int STS_W = 7;
  localparam logic [5:0] OFS_CHAIN_LO = 6'h00;
  localparam logic [5:0] OFS_CHAIN_HI = 6'h04;
  localparam logic [5:0] OFS_SRC = 6'h08;
  localparam logic [5:0] OFS_DST = 6'h10;
  localparam logic [5:0] OFS_CNT = 6'h18;
  localparam logic [5:0] OFS_SINC = 6'h20;
  localparam logic [5:0] OFS_DINC = 6'h28;
  localparam logic [5:0] OFS_CTL = 6'h30;
  localparam logic [5:0] OFS_STS = 6'h38;
  localparam logic [8:0] OFS_MASTER = 9'h150;

  // ********************************************************************
  // Field positions and reset values.
  // ********************************************************************
  localparam int CTL_ACTIVE = 0;
  localparam int CTL_CHAIN_EN = 1;
  localparam int CTL_SIMPLE = 2;
  localparam int CTL_IE_DONE = 3;
  localparam int CTL_IE_ERR = 4;
  localparam int CTL_IE_CHAIN = 5;
  localparam int CTL_STALL_LSB = 6;
  localparam int STS_STALL = 4;
  localparam int STS_DONE = 5;
  localparam int STS_CHAIN_END = 6;
  localparam int MST_ENABLE = 0;
  localparam int MST_DIS_LSB = 8;
  localparam int MST_EIS_LSB = 12;
  localparam logic [3:0] ERR_BUS = 4'h1;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [CTL_W-1:0] RST_CTL = 9'h000;
  localparam logic [STS_W-1:0] RST_STS = 7'h00;

  // ********************************************************************
  // Descriptor walk and transfer step.
  // ********************************************************************
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0008;
  localparam logic [2:0] DESC_LAST_SIMPLE = 3'h3;
  localparam logic [2:0] DESC_LAST_FULL = 3'h7;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;

  // ********************************************************************
  // Stall timing: one interval unit, scaled by a power of two per code.
  // ********************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int STALL_UNIT_NS = 1000;
  localparam int STALL_UNIT_CYC =
    (STALL_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b011,
    ST_CHECK = 3'b100
  } eng_state_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bus_req_t;

endpackage

// *** hw/stall_timer.sv ***
/*
 * Per-channel stall timer. Counts cycles since the channel's last system
 * bus access and pulses once when the programmed interval is passed.
 * Assumes the caller drops watch_in once the stall flag is set.
 */
`timescale 1ns/1ps
`default_nettype none
module stall_timer
  import dma_chain_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic watch_in,
  input wire logic access_in,
  input wire logic [2:0] code_in,
  output logic hit_out
);

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic hit_reg;
  logic hit_next;
  logic [15:0] limit;

  // ********************************************************************
  // Interval counter.
  // ********************************************************************
  // Code zero switches the watch off entirely.
  // Any access restarts the count.
  always_comb begin
    limit = 16'(STALL_UNIT_CYC) << code_in;
    cnt_next = cnt_reg;
    hit_next = 1'b0;
    if (!watch_in || access_in || code_in == 3'b000) begin
      cnt_next = 16'h0000;
    end else if (cnt_reg == limit) begin
      hit_next = 1'b1;
      cnt_next = 16'h0000;
    end else begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_reg <= 16'h0000;
      hit_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      hit_reg <= hit_next;
    end
  end

  assign hit_out = hit_reg;

endmodule
`default_nettype wire

// *** hw/channel_picker.sv ***
/*
 * Picks the lowest numbered channel that has work pending.
 * Purely combinational; the caller registers the choice.
 */
`timescale 1ns/1ps
`default_nettype none
module channel_picker
  import dma_chain_pkg::*;
(
  input wire logic [CH_NUM-1:0] want_in,
  output logic valid_out,
  output logic [1:0] idx_out
);

  // Scan downward so the lowest requester is the one that sticks.
  always_comb begin
    valid_out = 1'b0;
    idx_out = 2'b00;
    for (int i = CH_NUM - 1; i >= 0; i--) begin
      if (want_in[i]) begin
        valid_out = 1'b1;
        idx_out = 2'(i);
      end
    end
  end

endmodule
`default_nettype wire

// *** hw/dma_chain_seq.sv ***
/*
 * Four-channel DMA sequencer with descriptor chaining, stall watch and
 * per-channel interrupt lines. One engine serves one channel at a time.
 * Assumes a system bus target that answers each request with a one-cycle
 * ack, carrying read data and an error flag in that same cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module dma_chain_seq
  import dma_chain_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [8:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [31:0] rd_data_out,
  output bus_req_t bus_out,
  input wire logic bus_ack_in,
  input wire logic bus_err_in,
  input wire logic [31:0] bus_rdata_in,
  output logic [CH_NUM-1:0] irq_out
);

  // ********************************************************************
  // State.
  // ********************************************************************
  logic [31:0] chain_lo_reg [CH_NUM];
  logic [31:0] chain_lo_next [CH_NUM];
  logic [31:0] chain_hi_reg [CH_NUM];
  logic [31:0] chain_hi_next [CH_NUM];
  logic [31:0] src_reg [CH_NUM];
  logic [31:0] src_next [CH_NUM];
  logic [31:0] dst_reg [CH_NUM];
  logic [31:0] dst_next [CH_NUM];
  logic [31:0] cnt_reg [CH_NUM];
  logic [31:0] cnt_next [CH_NUM];
  logic [31:0] sinc_reg [CH_NUM];
  logic [31:0] sinc_next [CH_NUM];
  logic [31:0] dinc_reg [CH_NUM];
  logic [31:0] dinc_next [CH_NUM];
  logic [CTL_W-1:0] ctl_reg [CH_NUM];
  logic [CTL_W-1:0] ctl_next [CH_NUM];
  logic [STS_W-1:0] sts_reg [CH_NUM];
  logic [STS_W-1:0] sts_next [CH_NUM];
  logic [CH_NUM-1:0] fetch_reg;
  logic [CH_NUM-1:0] fetch_next;
  logic [CH_NUM-1:0] last_reg;
  logic [CH_NUM-1:0] last_next;
  logic enable_reg;
  logic enable_next;
  eng_state_t state_reg;
  eng_state_t state_next;
  logic [1:0] sel_reg;
  logic [1:0] sel_next;
  logic [2:0] idx_reg;
  logic [2:0] idx_next;
  logic [31:0] data_reg;
  logic [31:0] data_next;
  bus_req_t bus_reg;
  bus_req_t bus_next;
  logic [31:0] rd_reg;
  logic [31:0] rd_next;
  logic [CH_NUM-1:0] irq_reg;
  logic [CH_NUM-1:0] irq_next;

  logic [CH_NUM-1:0] want;
  logic pick_valid;
  logic [1:0] pick_idx;
  logic [CH_NUM-1:0] stall_hit;
  logic [CH_NUM-1:0] norm_irq;
  logic [CH_NUM-1:0] err_irq;
  logic [CH_NUM-1:0] access;
  logic [1:0] wch;
  logic [5:0] wofs;
  logic [1:0] s;
  logic [2:0] last_idx;
  logic [31:0] desc_addr;

  // ********************************************************************
  // Per-channel stall watch and interrupt causes.
  // ********************************************************************
  // The watch runs only while the channel is busy and the flag is clear,
  // so clearing the flag is what re-arms it.
  for (genvar c = 0; c < CH_NUM; c++) begin : g_ch
    assign want[c] = fetch_reg[c] || ctl_reg[c][CTL_ACTIVE];
    assign access[c] = bus_reg.req && bus_ack_in && sel_reg == 2'(c);
    assign norm_irq[c] =
      (sts_reg[c][STS_DONE] && ctl_reg[c][CTL_IE_DONE]) ||
      (sts_reg[c][STS_CHAIN_END] && ctl_reg[c][CTL_IE_CHAIN]);
    assign err_irq[c] = ctl_reg[c][CTL_IE_ERR] &&
      (sts_reg[c][STS_STALL] || sts_reg[c][3:0] != 4'h0);
    stall_timer u_stall (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .watch_in(ctl_reg[c][CTL_ACTIVE] && !sts_reg[c][STS_STALL]),
      .access_in(access[c]),
      .code_in(ctl_reg[c][CTL_STALL_LSB+:3]),
      .hit_out(stall_hit[c])
    );
  end

  channel_picker u_pick (
    .want_in(want),
    .valid_out(pick_valid),
    .idx_out(pick_idx)
  );

  // ********************************************************************
  // Register port, engine and status updates.
  // ********************************************************************
  // Order matters: software writes first, engine updates next, hardware
  // status sets last so an event never loses to a clear in its cycle.
  always_comb begin
    chain_lo_next = chain_lo_reg;
    chain_hi_next = chain_hi_reg;
    src_next = src_reg;
    dst_next = dst_reg;
    cnt_next = cnt_reg;
    sinc_next = sinc_reg;
    dinc_next = dinc_reg;
    ctl_next = ctl_reg;
    sts_next = sts_reg;
    fetch_next = fetch_reg;
    last_next = last_reg;
    enable_next = enable_reg;
    state_next = state_reg;
    sel_next = sel_reg;
    idx_next = idx_reg;
    data_next = data_reg;
    bus_next = bus_reg;
    rd_next = RST_WORD;
    wch = addr_in[7:6];
    wofs = addr_in[5:0];
    s = sel_reg;
    last_idx = ctl_reg[s][CTL_SIMPLE] ? DESC_LAST_SIMPLE : DESC_LAST_FULL;
    desc_addr = chain_lo_reg[s] + DESC_STRIDE * 32'(idx_reg);

    // Register writes. Status bits are cleared by writing ones.
    if (wr_en_in && addr_in == OFS_MASTER) begin
      enable_next = wr_data_in[MST_ENABLE];
    end
    if (wr_en_in && !addr_in[8]) begin
      case (wofs)
        OFS_CHAIN_LO: begin
          chain_lo_next[wch] = wr_data_in;
          last_next[wch] = 1'b0;
          // Only this half tests for zero and launches a chain.
          if ({chain_hi_reg[wch], wr_data_in} != 64'h0) begin
            fetch_next[wch] = 1'b1;
            ctl_next[wch][CTL_ACTIVE] = 1'b1;
            ctl_next[wch][CTL_CHAIN_EN] = 1'b1;
          end
        end
        OFS_CHAIN_HI: chain_hi_next[wch] = wr_data_in;
        OFS_SRC: src_next[wch] = wr_data_in;
        OFS_DST: dst_next[wch] = wr_data_in;
        OFS_CNT: cnt_next[wch] = wr_data_in;
        OFS_SINC: sinc_next[wch] = wr_data_in;
        OFS_DINC: dinc_next[wch] = wr_data_in;
        OFS_CTL: ctl_next[wch] = wr_data_in[CTL_W-1:0];
        OFS_STS: sts_next[wch] = sts_reg[wch] & ~wr_data_in[STS_W-1:0];
        default: ;
      endcase
    end

    // Engine. Each access drops the request for a cycle after its ack.
    case (state_reg)
      ST_IDLE: begin
        if (enable_reg && pick_valid) begin
          sel_next = pick_idx;
          idx_next = 3'h0;
          if (fetch_reg[pick_idx]) begin
            state_next = ST_FETCH;
          end else if (cnt_reg[pick_idx] != RST_WORD) begin
            state_next = ST_READ;
          end else begin
            sts_next[pick_idx][STS_DONE] = 1'b1;
            if (!ctl_reg[pick_idx][CTL_CHAIN_EN]) begin
              ctl_next[pick_idx][CTL_ACTIVE] = 1'b0;
            end else if (!last_reg[pick_idx]) begin
              fetch_next[pick_idx] = 1'b1;
            end else begin
              state_next = ST_CHECK; // Late appends are seen here.
            end
          end
        end
      end
      ST_FETCH: begin
        if (!bus_reg.req) begin
          bus_next.req = 1'b1;
          bus_next.we = 1'b0;
          bus_next.addr = desc_addr;
        end else if (bus_ack_in) begin
          bus_next.req = 1'b0;
          idx_next = idx_reg + 3'h1;
          case (idx_reg)
            3'h0: begin
              // Park the pointer: later words still walk the old base.
              data_next = bus_rdata_in;
              last_next[s] = bus_rdata_in == RST_WORD;
            end
            3'h1: src_next[s] = bus_rdata_in;
            3'h2: dst_next[s] = bus_rdata_in;
            3'h3: cnt_next[s] = bus_rdata_in;
            3'h4: sinc_next[s] = bus_rdata_in;
            3'h5: dinc_next[s] = bus_rdata_in;
            3'h6: begin
              ctl_next[s] = bus_rdata_in[CTL_W-1:0];
              ctl_next[s][CTL_ACTIVE] = 1'b1;
              ctl_next[s][CTL_CHAIN_EN] = 1'b1;
            end
            3'h7: sts_next[s] = bus_rdata_in[STS_W-1:0];
            default: ;
          endcase
          if (idx_reg == last_idx) begin
            fetch_next[s] = 1'b0;
            state_next = ST_IDLE;
            // A zero pointer keeps the current address.
            if (data_reg != RST_WORD) begin
              chain_lo_next[s] = data_reg;
            end
          end
        end
      end
      ST_CHECK: begin
        if (!bus_reg.req) begin
          bus_next.req = 1'b1;
          bus_next.we = 1'b0;
          bus_next.addr = chain_lo_reg[s];
        end else if (bus_ack_in) begin
          bus_next.req = 1'b0;
          state_next = ST_IDLE;
          if (bus_rdata_in != RST_WORD) begin
            chain_lo_next[s] = bus_rdata_in;
            last_next[s] = 1'b0;
            fetch_next[s] = 1'b1;
          end else begin
            sts_next[s][STS_CHAIN_END] = 1'b1;
            ctl_next[s][CTL_ACTIVE] = 1'b0;
            ctl_next[s][CTL_CHAIN_EN] = 1'b0;
          end
        end
      end
      ST_READ: begin
        if (!bus_reg.req) begin
          bus_next.req = 1'b1;
          bus_next.we = 1'b0;
          bus_next.addr = src_reg[s];
        end else if (bus_ack_in) begin
          bus_next.req = 1'b0;
          data_next = bus_rdata_in;
          state_next = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (!bus_reg.req) begin
          bus_next.req = 1'b1;
          bus_next.we = 1'b1;
          bus_next.addr = dst_reg[s];
          bus_next.wdata = data_reg;
        end else if (bus_ack_in) begin
          bus_next.req = 1'b0;
          src_next[s] = src_reg[s] + sinc_reg[s];
          dst_next[s] = dst_reg[s] + dinc_reg[s];
          cnt_next[s] = cnt_reg[s] > WORD_BYTES ?
            cnt_reg[s] - WORD_BYTES : RST_WORD;
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase

    // A failed access halts the channel and records why.
    if (bus_reg.req && bus_ack_in && bus_err_in) begin
      sts_next[s][3:0] = ERR_BUS;
      ctl_next[s][CTL_ACTIVE] = 1'b0;
      ctl_next[s][CTL_CHAIN_EN] = 1'b0;
      fetch_next[s] = 1'b0;
      bus_next.req = 1'b0;
      state_next = ST_IDLE;
    end

    // Stall only flags; the transfer carries on.
    for (int c = 0; c < CH_NUM; c++) begin
      if (stall_hit[c]) begin
        sts_next[c][STS_STALL] = 1'b1;
      end
    end

    // Read data stand for exactly one cycle.
    if (rd_en_in && addr_in == OFS_MASTER) begin
      rd_next[MST_ENABLE] = enable_reg;
      rd_next[MST_DIS_LSB+:4] = norm_irq;
      rd_next[MST_EIS_LSB+:4] = err_irq;
    end else if (rd_en_in && !addr_in[8]) begin
      case (wofs)
        OFS_CHAIN_LO: rd_next = chain_lo_reg[wch];
        OFS_CHAIN_HI: rd_next = chain_hi_reg[wch];
        OFS_SRC: rd_next = src_reg[wch];
        OFS_DST: rd_next = dst_reg[wch];
        OFS_CNT: rd_next = cnt_reg[wch];
        OFS_SINC: rd_next = sinc_reg[wch];
        OFS_DINC: rd_next = dinc_reg[wch];
        OFS_CTL: rd_next = 32'(ctl_reg[wch]);
        OFS_STS: rd_next = 32'(sts_reg[wch]);
        default: rd_next = RST_WORD;
      endcase
    end

    irq_next = norm_irq | err_irq;
  end

  // ********************************************************************
  // Registers.
  // ********************************************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int c = 0; c < CH_NUM; c++) begin
        chain_lo_reg[c] <= RST_WORD;
        chain_hi_reg[c] <= RST_WORD;
        src_reg[c] <= RST_WORD;
        dst_reg[c] <= RST_WORD;
        cnt_reg[c] <= RST_WORD;
        sinc_reg[c] <= RST_WORD;
        dinc_reg[c] <= RST_WORD;
        ctl_reg[c] <= RST_CTL;
        sts_reg[c] <= RST_STS;
      end
      fetch_reg <= 4'h0;
      last_reg <= 4'h0;
      enable_reg <= 1'b0;
      state_reg <= ST_IDLE;
      sel_reg <= 2'h0;
      idx_reg <= 3'h0;
      data_reg <= RST_WORD;
      bus_reg <= '0;
      rd_reg <= RST_WORD;
      irq_reg <= 4'h0;
    end else begin
      chain_lo_reg <= chain_lo_next;
      chain_hi_reg <= chain_hi_next;
      src_reg <= src_next;
      dst_reg <= dst_next;
      cnt_reg <= cnt_next;
      sinc_reg <= sinc_next;
      dinc_reg <= dinc_next;
      ctl_reg <= ctl_next;
      sts_reg <= sts_next;
      fetch_reg <= fetch_next;
      last_reg <= last_next;
      enable_reg <= enable_next;
      state_reg <= state_next;
      sel_reg <= sel_next;
      idx_reg <= idx_next;
      data_reg <= data_next;
      bus_reg <= bus_next;
      rd_reg <= rd_next;
      irq_reg <= irq_next;
    end
  end

  assign rd_data_out = rd_reg;
  assign bus_out = bus_reg;
  assign irq_out = irq_reg;

endmodule
`default_nettype wire

// *** dv/bus_target.sv ***
/* Memory target on the system bus for the sequencer bench.
   Assumes one request at a time, held until its ack. */
`timescale 1ns/1ps
`default_nettype none
module bus_target
  import dma_chain_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire bus_req_t bus_in,
  input wire logic [7:0] dly_in,
  input wire logic [31:0] bad_in,
  output logic ack_out,
  output logic err_out,
  output logic [31:0] rdata_out
);
  // ****
  // Memory and answer
  // ****
  logic [31:0] mem [0:256-1];
  logic [7:0] wait_reg;
  // Acks after dly_in cycles. Read data toggles while not valid, so a
  // stale value can never pass for a fresh one.
  always @(posedge clk_in) begin
    ack_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if (rst_in) begin
      wait_reg <= 8'h00;
      err_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
    end else if (bus_in.req && !ack_out) begin
      wait_reg <= wait_reg + 8'h01;
      if (wait_reg >= dly_in) begin
        wait_reg <= 8'h00;
        ack_out <= 1'b1;
        err_out <= bus_in.addr == bad_in;
        rdata_out <= mem[bus_in.addr[9:2]];
        if (bus_in.we && bus_in.addr != bad_in) begin
          mem[bus_in.addr[9:2]] <= bus_in.wdata;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** dv/dma_chain_seq_assertions.sv ***
/* Port checker for the chained DMA sequencer.
   Assumes the bind below and the single clock of the block. */
`timescale 1ns/1ps
`default_nettype none
module dma_chain_seq_checker
  import dma_chain_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [8:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [31:0] rd_data_out,
  input wire bus_req_t bus_out,
  input wire logic bus_ack_in,
  input wire logic bus_err_in,
  input wire logic [31:0] bus_rdata_in,
  input wire logic [CH_NUM-1:0] irq_out
);
  // ****
  // Mirror of the global enable
  // ****
  logic en_reg;
  logic en_next;
  // Only port writes change it, so the mirror is exact.
  always_comb begin
    en_next = en_reg;
    if (wr_en_in && addr_in == OFS_MASTER) en_next = wr_data_in[MST_ENABLE];
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) en_reg <= 1'b0;
    else en_reg <= en_next;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ****
  // Properties
  // ****
  a_reset_quiet: assert property ($fell(rst_in) |->
    bus_out == '0 && irq_out == '0 && rd_data_out == '0)
    else $error("outputs not clear after reset");
  a_read_idle: assert property (!rd_en_in |=> rd_data_out == '0)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (
    rd_en_in && addr_in == 9'h100 |=> rd_data_out == '0)
    else $error("unmapped read not zero");
  a_master_echo: assert property (rd_en_in && addr_in == OFS_MASTER |=>
    rd_data_out[MST_ENABLE] == $past(en_reg) && rd_data_out[7:1] == '0)
    else $error("master enable read back wrong");
  a_req_holds: assert property (bus_out.req && !bus_ack_in |=>
    bus_out.req && $stable(bus_out.we) && $stable(bus_out.addr) &&
    $stable(bus_out.wdata))
    else $error("bus request changed before ack");
  a_req_drops: assert property (bus_ack_in |=> !bus_out.req)
    else $error("bus request held after ack");
  a_idle_when_off: assert property (!en_reg && !bus_out.req |=>
    !bus_out.req)
    else $error("bus access while globally disabled");
  a_irq_fall_cause: assert property (|(~irq_out & $past(irq_out)) |->
    $past(wr_en_in) || $past(wr_en_in, 2) || $past(bus_ack_in, 2) ||
    $past(bus_ack_in, 3))
    else $error("interrupt dropped with no cause");
endmodule
bind dma_chain_seq dma_chain_seq_checker u_dma_chain_seq_checker (
  .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
  .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
  .rd_data_out(rd_data_out), .bus_out(bus_out), .bus_ack_in(bus_ack_in),
  .bus_err_in(bus_err_in), .bus_rdata_in(bus_rdata_in), .irq_out(irq_out)
);
`default_nettype wire

// *** dv/dma_chain_seq_bench.sv ***
/* Self-checking bench for the chained DMA sequencer.
   Assumes bus_target as the memory and a 25 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module dma_chain_seq_bench;
  import dma_chain_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wr_en_in = 1'b0;
  logic rd_en_in = 1'b0;
  logic [8:0] addr_in = 9'h000;
  logic [31:0] wr_data_in = 32'h0000_0000;
  logic [31:0] bad = 32'hFFFF_FFFC;
  logic [31:0] rd_data_out, bus_rdata_in, rv;
  logic [7:0] dly = 8'h00;
  logic bus_ack_in, bus_err_in;
  logic [CH_NUM-1:0] irq_out;
  bus_req_t bus_out;
  int n_fail = 0;
  int tests_run = 0;
  int n_acc = 0;
  // ****
  // Clock, access count and instances
  // ****
  always #20 clk_in = ~clk_in;
  always @(posedge clk_in) if (bus_ack_in) n_acc <= n_acc + 1;
  dma_chain_seq u_dma_chain_seq (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .bus_out(bus_out), .bus_ack_in(bus_ack_in),
    .bus_err_in(bus_err_in), .bus_rdata_in(bus_rdata_in), .irq_out(irq_out)
  );
  bus_target u_bus_target (
    .clk_in(clk_in), .rst_in(rst_in), .bus_in(bus_out), .dly_in(dly),
    .bad_in(bad), .ack_out(bus_ack_in), .err_out(bus_err_in),
    .rdata_out(bus_rdata_in)
  );
  // ****
  // Tasks
  // ****
  task automatic end_sim;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [8:0] ra(int c, logic [5:0] o);
    return {1'b0, c[1:0], o};
  endfunction
  function automatic logic [31:0] sts(logic d, e, s, logic [3:0] c);
    return 32'({e, d, s, c});
  endfunction
  // Strobes drop and one edge passes, so no signal is set twice at once.
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rchk(input logic [8:0] a, input logic [31:0] e);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    #1 rv = rd_data_out;
    @(posedge clk_in);
    if (e !== 32'hFFFF_FFFF) chk(rv, e);
  endtask
  // Polls control until the busy bits drop; a hang ends the run.
  task automatic wait_idle(input int c);
    rv = 32'hFFFF_FFFF;
    for (int i = 0; i < 500 && (rv[CTL_ACTIVE] || rv[CTL_CHAIN_EN]); i++)
      rchk(ra(c, OFS_CTL), 32'hFFFF_FFFF);
    if (rv[CTL_ACTIVE] !== 1'b0 || rv[CTL_CHAIN_EN] !== 1'b0) begin
      n_fail++;
      $display("wrong value at %0t: channel %0d stuck busy", $time, c);
      end_sim();
    end
  endtask
  task automatic plain(input int c, input logic [31:0] s, d, n, ctl);
    wr(ra(c, OFS_SRC), s);
    wr(ra(c, OFS_DST), d);
    wr(ra(c, OFS_CNT), n);
    wr(ra(c, OFS_SINC), WORD_BYTES);
    wr(ra(c, OFS_DINC), WORD_BYTES);
    wr(ra(c, OFS_CHAIN_LO), 32'h0);
    wr(ra(c, OFS_STS), 32'h7F);
    wr(ra(c, OFS_CTL), ctl | 32'h1);
  endtask
  task automatic chain(input int c, input logic [31:0] h, ctl);
    wr(ra(c, OFS_CNT), 32'h0);
    wr(ra(c, OFS_SINC), WORD_BYTES);
    wr(ra(c, OFS_DINC), WORD_BYTES);
    wr(ra(c, OFS_STS), 32'h7F);
    wr(ra(c, OFS_CTL), ctl);
    wr(ra(c, OFS_CHAIN_HI), 32'h0);
    wr(ra(c, OFS_CHAIN_LO), h);
    wait_idle(c);
  endtask
  task automatic put_desc(input logic [31:0] a, p, s, d, n, i, c, st);
    logic [31:0] f [8];
    f = '{p, s, d, n, i, i, c, st};
    for (int k = 0; k < 8; k++) u_bus_target.mem[a[9:2] + 2 * k] = f[k];
  endtask
  task automatic chk_copy(input logic [31:0] s, d, n);
    for (int k = 0; k < n / 4; k++)
      chk(u_bus_target.mem[d[9:2] + k], u_bus_target.mem[s[9:2] + k]);
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    int k;
    logic [31:0] n, old;
    rv = $urandom(25216);
    for (k = 0; k < 256; k++) u_bus_target.mem[k] = $urandom;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rchk(ra(0, OFS_CTL), 32'(RST_CTL));
    rchk(9'h100, 32'h0);
    // Armed while globally off: nothing may move until enabled.
    n = 32'h4 * (1 + $urandom % 4);
    dly <= 8'($urandom % 4);
    plain(0, 32'h200, 32'h300, n, 32'h8);
    repeat (20) @(posedge clk_in);
    chk(32'(n_acc), 32'h0);
    wr(OFS_MASTER, 32'h1);
    wait_idle(0);
    chk_copy(32'h200, 32'h300, n);
    rchk(ra(0, OFS_STS), sts(1, 0, 0, 4'h0));
    chk(32'(irq_out[0]), 32'h1);
    rchk(OFS_MASTER, 32'h0000_0101);
    wr(ra(0, OFS_STS), 32'h7F);
    @(posedge clk_in);
    chk(32'(irq_out[0]), 32'h0);
    // A failing source read halts the channel.
    old = u_bus_target.mem[8'hE0];
    bad <= 32'h200;
    plain(1, 32'h200, 32'h380, 32'h8, 32'h10);
    wait_idle(1);
    rchk(ra(1, OFS_STS), sts(0, 0, 0, ERR_BUS));
    chk(u_bus_target.mem[8'hE0], old);
    chk(32'(irq_out[1]), 32'h1);
    rchk(OFS_MASTER, 32'h0000_2001);
    bad <= 32'hFFFF_FFFC;
    // Stall watch: off, tripped by a slow target, quiet when prompt.
    for (k = 0; k < 3; k++) begin
      dly <= (k == 2) ? 8'h28 : 8'h50;
      plain(0, 32'h200, 32'h300, 32'h4, 32'h10 | (32'(k != 0) << 6));
      wait_idle(0);
      rchk(ra(0, OFS_STS), sts(1, 0, k == 1, 4'h0));
      chk(32'(irq_out[0]), 32'(k == 1));
    end
    dly <= 8'h01;
    // Full two-descriptor chain; the last one ends the list.
    put_desc(32'h100, 32'h140, 32'h200, 32'h320, 32'h8, 32'h4, 32'h28, 0);
    put_desc(32'h140, 32'h0, 32'h210, 32'h340, 32'h4, 32'h4, 32'h20, 0);
    chain(2, 32'h100, 32'h0);
    rchk(ra(2, OFS_CHAIN_LO), 32'h140);
    rchk(ra(2, OFS_STS), sts(1, 1, 0, 4'h0));
    rchk(ra(2, OFS_CTL), 32'h20);
    chk(32'(irq_out[2]), 32'h1);
    chk_copy(32'h200, 32'h320, 32'h8);
    chk_copy(32'h210, 32'h340, 32'h4);
    // Simple chain keeps increments, control and status.
    put_desc(32'h180, 0, 32'h220, 32'h360, 32'h4, 32'h10, 0, 32'h7F);
    chain(3, 32'h180, 32'h0C);
    rchk(ra(3, OFS_SINC), WORD_BYTES);
    rchk(ra(3, OFS_CTL), 32'h0C);
    rchk(ra(3, OFS_STS), sts(1, 1, 0, 4'h0));
    chk(32'(irq_out[3]), 32'h1);
    chk_copy(32'h220, 32'h360, 32'h4);
    // Append while the list runs; the end-of-chain check picks it up.
    put_desc(32'h1C0, 0, 32'h230, 32'h370, 32'h4, 0, 0, 0);
    dly <= 8'h10;
    wr(ra(3, OFS_STS), 32'h7F);
    wr(ra(3, OFS_CHAIN_LO), 32'h180);
    repeat (40) @(posedge clk_in);
    u_bus_target.mem[8'h60] = 32'h1C0;
    rchk(ra(3, OFS_CTL), 32'h0F);
    wait_idle(3);
    rchk(ra(3, OFS_CHAIN_LO), 32'h1C0);
    rchk(ra(3, OFS_STS), sts(1, 1, 0, 4'h0));
    chk_copy(32'h230, 32'h370, 32'h4);
    end_sim();
  end
endmodule
`default_nettype wire
